// ===== design/cs_search_top.sv
/*
 * Search memory of 32 words by 32 bits with per-bit don't-care, three
 * result modes, optional input and output stages and a lookup table.
 * Assumes user logic on the same clock drives writes and search words.
 */
// What this block does
// [R1] One table holds 32 entries of 32 bits, compared against each search word.
// [R2] All entries compared in parallel; match flag high when any written entry equals, entries 0 to 15 only in fast mode.
// [R3] Don't-care stored bits never block a match.
// [R4] Single, multiple and fast multiple modes, encoded or per-line results.
// [R5] Encoded output gives the binary index of the matching entry.
// [R6] Unencoded output uses 16 lines over two cycles except in fast mode, raising matching lines.
// [R7] Unencoded compares 31 bits; the top bit selects the bank of lines.
// [R8] Bank one shows odd entries, bank zero shows even entries.
// [R9] Single mode: full-care write takes two cycles, encoded search one.
// [R10] Single mode makes encoded and line results itself.
// [R11] Multiple mode: 16 lines per cycle, all 32 entries over two cycles.
// [R12] User logic adds a priority encoder for binary multiple-mode results.
// [R13] Fast mode: 16 valid lines in one cycle, table limited to 16 entries.
// [R14] Table words preloaded at configuration but marked invalid, so they match only once written during operation.
// [R15] Write takes two cycles, three with don't-care bits; writer waits.
// [R16] Wider or deeper tables are built outside from several blocks.
// [R17] Independent input and output enables; six optional register stages.
// [R18] Write enable, read strobe, clock enables and synchronous clear honoured.
// [R19] Every register cleared, and the table reloaded with its preload and marked invalid, by local, global or device-wide reset.
// [R20] Lookup table returns the preloaded word for each address.
// [R21] No match keeps the match flag and all lines low.
// [R22] Outside encoder reports the lowest matching entry.
`timescale 1ns/1ps
module cs_search_top
	import cs_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        aclr_local,
	input  wire logic        aclr_global,
	input  wire logic        sclr,
	input  wire logic        in_ce,
	input  wire logic        out_ce,
	input  wire logic [1:0]  mode,
	input  wire logic        enc_sel,
	input  wire logic [5:0]  reg_opt,
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_addr,
	input  wire logic [31:0] wr_data,
	input  wire logic [31:0] wr_care,
	output logic             wr_busy,
	input  wire logic        read_strobe,
	input  wire logic [31:0] srch_data,
	output logic             srch_ready,
	output logic             res_valid,
	output logic             match,
	output logic [4:0]       match_idx,
	output logic [15:0]      lines,
	output logic             lines_phase,
	input  wire logic [4:0]  lut_addr,
	output logic [31:0]      lut_data
);
	////////////////////////////////////////////////////////////////////////////
	// Clears and optional stages
	logic        arst_n;
	logic [63:0] din_e;
	logic [4:0]  wa_e;
	logic        we_e;
	logic [31:0] key_e;
	logic        re_e;

	// [R19] combined clears
	assign arst_n = rstn & ~aclr_local & ~aclr_global;

	// [R17] optional stages
	cs_opt_reg #(.W(64)) u_din (.mclk(mclk), .arst_n(arst_n), .use_reg(reg_opt[CS_OPT_DIN]),
		.ce(in_ce), .sclr(sclr), .d({wr_care, wr_data}), .q(din_e));
	cs_opt_reg #(.W(5)) u_wa (.mclk(mclk), .arst_n(arst_n), .use_reg(reg_opt[CS_OPT_WADDR]),
		.ce(in_ce), .sclr(sclr), .d(wr_addr), .q(wa_e));
	cs_opt_reg #(.W(1)) u_we (.mclk(mclk), .arst_n(arst_n), .use_reg(reg_opt[CS_OPT_WE]),
		.ce(in_ce), .sclr(sclr), .d(wr_en), .q(we_e));
	cs_opt_reg #(.W(32)) u_key (.mclk(mclk), .arst_n(arst_n), .use_reg(reg_opt[CS_OPT_RADDR]),
		.ce(in_ce), .sclr(sclr), .d(srch_data), .q(key_e));
	cs_opt_reg #(.W(1)) u_re (.mclk(mclk), .arst_n(arst_n), .use_reg(reg_opt[CS_OPT_RE]),
		.ce(in_ce), .sclr(sclr), .d(read_strobe), .q(re_e));

	////////////////////////////////////////////////////////////////////////////
	// Table and write sequence
	// [R1] 32 by 32 table
	logic [31:0] data_q [CS_WORDS];
	logic [31:0] data_d [CS_WORDS];
	logic [31:0] care_q [CS_WORDS];
	logic [31:0] care_d [CS_WORDS];
	logic [31:0] valid_q;
	logic [31:0] valid_d;
	cs_wst_t     wst_q;
	cs_wst_t     wst_d;
	logic [4:0]  wa_q;
	logic [4:0]  wa_d;
	logic [31:0] wd_q;
	logic [31:0] wd_d;
	logic [31:0] wm_q;
	logic [31:0] wm_d;

	always_comb begin
		data_d  = data_q;
		care_d  = care_q;
		valid_d = valid_q;
		wst_d   = wst_q;
		wa_d    = wa_q;
		wd_d    = wd_q;
		wm_d    = wm_q;
		case (wst_q)
			CS_W_IDLE: begin
				// [R18] write enable
				if (we_e && in_ce) begin
					wst_d = CS_W_DATA;
					wa_d  = wa_e;
					wd_d  = din_e[31:0];
					wm_d  = din_e[63:32];
				end
			end
			CS_W_DATA: begin
				// [R15] second write cycle
				if (in_ce) begin
					data_d[wa_q]  = wd_q;
					care_d[wa_q]  = CS_CARE_ALL;
					valid_d[wa_q] = &wm_q;
					wst_d         = (&wm_q) ? CS_W_IDLE : CS_W_MASK;
				end
			end
			CS_W_MASK: begin
				// [R15] third cycle for don't-care
				if (in_ce) begin
					care_d[wa_q]  = wm_q;
					valid_d[wa_q] = 1'b1;
					wst_d         = CS_W_IDLE;
				end
			end
			default: wst_d = CS_W_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			// [R14] configuration preload
			for (int i = 0; i < CS_WORDS; i++) begin
				data_q[i] <= cs_init_word(i);
				care_q[i] <= CS_CARE_ALL;
			end
			valid_q <= CS_INIT_VALID;
			wst_q   <= CS_W_IDLE;
			wa_q    <= 5'h00;
			wd_q    <= 32'h0000_0000;
			wm_q    <= 32'h0000_0000;
		end else begin
			data_q  <= data_d;
			care_q  <= care_d;
			valid_q <= valid_d;
			wst_q   <= wst_d;
			wa_q    <= wa_d;
			wd_q    <= wd_d;
			wm_q    <= wm_d;
		end
	end

	assign wr_busy = (wst_q != CS_W_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Parallel compare
	logic        enc_path;
	logic [31:0] cmask;
	logic [31:0] hitm;
	logic [4:0]  first_idx;
	logic [15:0] bmask;
	logic        take;

	// [R10] encoded result only in single mode
	assign enc_path = (mode == CS_SINGLE) && enc_sel;
	// [R7] top bit kept out of unencoded compare
	assign cmask    = enc_path ? CS_CARE_ALL : CS_CARE_UNENC;
	// [R8] bank parity
	assign bmask    = key_e[CS_BANK_BIT] ? CS_MASK_ODD : CS_MASK_EVEN;

	always_comb begin
		hitm      = 32'h0000_0000;
		first_idx = 5'h00;
		for (int i = 0; i < CS_WORDS; i++) begin
			// [R2] [R3] masked compare of every entry
			hitm[i] = valid_q[i] && (((data_q[i] ^ key_e) & care_q[i] & cmask) == '0);
		end
		// [R13] fast mode searches 16 entries
		if (mode == CS_FAST) begin
			hitm[31:CS_FAST_WORDS] = '0;
		end
		// [R5] binary index, lowest entry first
		for (int i = CS_WORDS - 1; i >= 0; i--) begin
			if (hitm[i]) begin
				first_idx = 5'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result stage
	logic        valid_r_q;
	logic        valid_r_d;
	logic        match_q;
	logic        match_d;
	logic [4:0]  idx_q;
	logic [4:0]  idx_d;
	logic [15:0] lines_q;
	logic [15:0] lines_d;
	logic        lines_phase_q;
	logic        lines_phase_d;
	logic [31:0] hit_q;
	logic [31:0] hit_d;
	logic [15:0] bank_q;
	logic [15:0] bank_d;
	logic [15:0] hit_lo;
	logic [23:0] out_e;

	assign hit_lo = hitm[15:0] & bmask;

	assign srch_ready = out_ce && (lines_phase_q == 1'b0);
	assign take       = re_e && in_ce && srch_ready;

	always_comb begin
		valid_r_d     = valid_r_q;
		match_d       = match_q;
		idx_d         = idx_q;
		lines_d       = lines_q;
		lines_phase_d = lines_phase_q;
		hit_d         = hit_q;
		bank_d        = bank_q;
		if (out_ce) begin
			valid_r_d = 1'b0;
			if (sclr) begin
				// [R18] synchronous clear
				match_d       = 1'b0;
				idx_d         = 5'h00;
				lines_d       = 16'h0000;
				lines_phase_d = 1'b0;
				hit_d         = 32'h0000_0000;
			end else if (lines_phase_q) begin
				// [R11] upper 16 entries in second cycle
				lines_d       = hit_q[31:16] & bank_q;
				lines_phase_d = 1'b0;
				valid_r_d     = 1'b1;
			end else if (take) begin
				// [R21] match follows the hit vector
				match_d   = |hitm;
				hit_d     = hitm;
				bank_d    = bmask;
				valid_r_d = 1'b1;
				idx_d     = enc_path ? first_idx : 5'h00;
				// [R6] [R4] lower lines first, second cycle unless fast or encoded
				lines_d       = enc_path ? 16'h0000 : hit_lo;
				lines_phase_d = !enc_path && (mode != CS_FAST);
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			valid_r_q     <= 1'b0;
			match_q       <= 1'b0;
			idx_q         <= 5'h00;
			lines_q       <= 16'h0000;
			lines_phase_q <= 1'b0;
			hit_q         <= 32'h0000_0000;
			bank_q        <= 16'h0000;
		end else begin
			valid_r_q     <= valid_r_d;
			match_q       <= match_d;
			idx_q         <= idx_d;
			lines_q       <= lines_d;
			lines_phase_q <= lines_phase_d;
			hit_q         <= hit_d;
			bank_q        <= bank_d;
		end
	end

	// [R17] optional output stage
	cs_opt_reg #(.W(24)) u_dout (.mclk(mclk), .arst_n(arst_n),
		.use_reg(reg_opt[CS_OPT_DOUT]), .ce(out_ce), .sclr(sclr),
		.d({valid_r_q, match_q, idx_q, lines_q, lines_phase_q}), .q(out_e));

	assign res_valid   = out_e[23];
	assign match       = out_e[22];
	assign match_idx   = out_e[21:17];
	assign lines       = out_e[16:1];
	assign lines_phase = out_e[0];

	////////////////////////////////////////////////////////////////////////////
	// Lookup table
	cs_rom_if    rom_b ();
	logic [31:0] lut_q;

	assign rom_b.addr = lut_addr;

	cs_lut_rom u_rom (.port_r(rom_b.rom));

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lut_q <= 32'h0000_0000;
		end else begin
			lut_q <= rom_b.data;
		end
	end

	assign lut_data = lut_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	sequence lower_half_s;
		lines_phase_q && valid_r_q;
	endsequence

	sequence upper_half_s;
		!lines_phase_q && valid_r_q && (lines_q == (hit_q[31:16] & bank_q));
	endsequence

	wr_two_cyc_a: assert property ((wst_q == CS_W_DATA) && in_ce && (&wm_q) // [R9]
		|=> wst_q == CS_W_IDLE) else $error("full-care write did not end in two cycles");
	wr_mask_cyc_a: assert property ((wst_q == CS_W_DATA) && in_ce && !(&wm_q) // [R15]
		|=> ((wst_q == CS_W_MASK) && !valid_q[wa_q]) ##1 (!in_ce || valid_q[wa_q]))
		else $error("don't-care write missed third cycle");
	match_set_a: assert property (take && !sclr && (|hitm) |=> match_q) // [R2]
		else $error("match flag not raised on hit");
	no_match_a: assert property (take && !sclr && !(|hitm) // [R21]
		|=> !match_q && (lines_q == 16'h0000)) else $error("flag or line high without hit");
	two_phase_a: assert property (take && !sclr && !enc_path && (mode != CS_FAST) // [R11]
		|=> (lower_half_s ##0 (!out_ce || sclr)) or (lower_half_s ##1 upper_half_s))
		else $error("second half of lines not presented");
	fast_one_a: assert property (take && !sclr && !enc_path && (mode == CS_FAST) // [R13]
		|=> !lines_phase_q && (lines_q == $past(hit_lo))) else $error("fast mode not one cycle");
	bank_par_a: assert property (valid_r_q && (bank_q == CS_MASK_EVEN) // [R8]
		|-> (lines_q & CS_MASK_ODD) == 16'h0000) else $error("odd line high on even bank");
	enc_idx_a: assert property (take && !sclr && enc_path && (|hitm) // [R5]
		|=> hit_q[idx_q] && ((hit_q & ((32'h0000_0001 << idx_q) - 32'h0000_0001)) == '0))
		else $error("encoded index not lowest hit");
	sclr_res_a: assert property (sclr && out_ce |=> !valid_r_q && !match_q) // [R18]
		else $error("synchronous clear ignored");

endmodule : cs_search_top

// ===== design/cs_pkg.sv
/*
 * Shared constants, types and the preload pattern of the search block.
 * Assumes a single 20 MHz clock and no register bus.
 */
package cs_pkg;

	localparam int          CS_WORDS      = 32;
	localparam int          CS_WIDTH      = 32;
	localparam int          CS_AW         = 5;
	localparam int          CS_LINES      = 16;
	localparam int          CS_FAST_WORDS = 16;
	localparam int          CS_BANK_BIT   = 31;

	// Positions in the register option vector (1 = stage registered)
	localparam int          CS_OPT_DIN    = 0;
	localparam int          CS_OPT_DOUT   = 1;
	localparam int          CS_OPT_RADDR  = 2;
	localparam int          CS_OPT_WADDR  = 3;
	localparam int          CS_OPT_WE     = 4;
	localparam int          CS_OPT_RE     = 5;
	localparam int          CS_OPT_BITS   = 6;

	localparam logic [31:0] CS_INIT_VALID = 32'h0000_0000;
	localparam logic [31:0] CS_CARE_ALL   = 32'hFFFF_FFFF;
	localparam logic [31:0] CS_CARE_UNENC = 32'h7FFF_FFFF;
	localparam logic [15:0] CS_MASK_ODD   = 16'hAAAA;
	localparam logic [15:0] CS_MASK_EVEN  = 16'h5555;

	typedef enum logic [1:0] {
		CS_SINGLE = 2'b00,
		CS_MULTI  = 2'b01,
		CS_FAST   = 2'b10
	} cs_mode_t;

	typedef enum logic [1:0] {
		CS_W_IDLE = 2'b00,
		CS_W_DATA = 2'b01,
		CS_W_MASK = 2'b10
	} cs_wst_t;

	// Pattern loaded at configuration, shared by the table and the lookup table
	function automatic logic [31:0] cs_init_word(input int idx);
		logic [7:0] b;
		b = 8'(idx);
		return {b, ~b, b ^ 8'h5A, 8'hC3};
	endfunction : cs_init_word

endpackage : cs_pkg

// ===== design/cs_rom_if.sv
/*
 * Address and word of the configuration-time lookup table.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface cs_rom_if;
	logic [4:0]  addr;
	logic [31:0] data;

	modport user (output addr, input data);
	modport rom  (input addr, output data);
endinterface : cs_rom_if

// ===== design/cs_opt_reg.sv
/*
 * Optional input or output stage: registered or passed straight through.
 * Assumes use_reg is held steady during operation.
 */
`timescale 1ns/1ps
module cs_opt_reg #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic         use_reg,
	input  wire logic         ce,
	input  wire logic         sclr,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage_q;
	logic [W-1:0] stage_d;

	always_comb begin
		stage_d = stage_q;
		if (ce) begin
			stage_d = sclr ? '0 : d;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stage_q <= '0;
		end else begin
			stage_q <= stage_d;
		end
	end

	assign q = use_reg ? stage_q : d;
endmodule : cs_opt_reg

// ===== design/cs_lut_rom.sv
/*
 * Fixed function table filled at configuration; pure lookup.
 * Assumes the caller registers the returned word.
 */
`timescale 1ns/1ps
module cs_lut_rom
	import cs_pkg::*;
(
	cs_rom_if.rom port_r
);
	// [R20] fixed lookup
	always_comb begin
		port_r.data = cs_init_word(int'(port_r.addr));
	end
endmodule : cs_lut_rom

// ===== bench/cs_prio_enc.sv
/*
 * User-side priority encoder that turns the two cycles of result lines into
 * one entry number.
 * Assumes the first result cycle is flagged by lines_phase.
 */
`timescale 1ns/1ps
module cs_prio_enc (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        res_valid,
	input  wire logic [15:0] lines,
	input  wire logic        lines_phase,
	output logic             enc_hit,
	output logic [4:0]       enc_idx
);
////////////////////////////////////////////////////////////////////////////////
	logic [15:0] lo_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lo_q    <= 16'h0000;
			enc_hit <= 1'b0;
			enc_idx <= 5'h00;
		end else if (res_valid && lines_phase) begin
			lo_q <= lines;
		end else if (res_valid) begin
			enc_hit <= |{lines, lo_q};
			enc_idx <= 5'h00;
			// Scanning downward leaves the lowest set line as the final value
			for (int k = 31; k >= 0; k--) begin
				if (k < 16 ? lo_q[k] : lines[k - 16]) begin
					enc_idx <= 5'(k);
				end
			end
		end
	end
endmodule : cs_prio_enc

// ===== bench/tb_top.sv
/*
 * Self-checking bench of the search block: writes, searches in every result
 * mode, output, search-word and strobe stages, input enable and clears.
 * Assumes one 20 MHz clock and a user-side encoder model.
 */
`timescale 1ns/1ps
module tb_top;
	import cs_pkg::*;
////////////////////////////////////////////////////////////////////////////////
	logic        mclk, rstn, aclr_local, aclr_global, sclr, in_ce, out_ce;
	logic        enc_sel, wr_en, read_strobe, wr_busy, srch_ready, res_valid;
	logic        match, lines_phase, enc_hit, m0, v0, v1, p0, p1, vend;
	logic [1:0]  mode;
	logic [5:0]  reg_opt;
	logic [4:0]  wr_addr, lut_addr, match_idx, enc_idx, i0;
	logic [31:0] wr_data, wr_care, srch_data, lut_data;
	logic [15:0] lines, l0, l1;
	int          err_count, total_checks;

	cs_search_top dut (.mclk, .rstn, .aclr_local, .aclr_global, .sclr, .in_ce,
		.out_ce, .mode, .enc_sel, .reg_opt, .wr_en, .wr_addr, .wr_data, .wr_care,
		.wr_busy, .read_strobe, .srch_data, .srch_ready, .res_valid, .match,
		.match_idx, .lines, .lines_phase, .lut_addr, .lut_data);

	cs_prio_enc pe (.mclk, .rstn, .res_valid, .lines, .lines_phase, .enc_hit,
		.enc_idx);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
////////////////////////////////////////////////////////////////////////////////
	task automatic chk_bit(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask : chk_bit

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_val

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic tend(input string name);
		$display("test %s done", name);
	endtask : tend

	task automatic cfg(input logic [1:0] m, input logic e, input logic [5:0] o);
		@(posedge mclk);
		mode    <= m;
		enc_sel <= e;
		reg_opt <= o;
	endtask : cfg

	// Write one entry; the busy span is counted and compared
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c);
		int n;
		@(posedge mclk);
		wr_en   <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		wr_care <= c;
		@(posedge mclk);
		wr_en <= 1'b0;
		n = 0;
		#1;
		while (wr_busy === 1'b1 && n < 8) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk_val(32'(n), (c === CS_CARE_ALL) ? 32'h1 : 32'h2, "write busy span");
	endtask : wr

	// One search; samples the answer cycle, the one after and a third
	task automatic srch(input logic [31:0] w, input int lat);
		@(posedge mclk);
		read_strobe <= 1'b1;
		srch_data   <= w;
		@(posedge mclk);
		read_strobe <= 1'b0;
		repeat (lat - 1) @(posedge mclk);
		#1;
		{v0, m0, i0, l0, p0} = {res_valid, match, match_idx, lines, lines_phase};
		@(posedge mclk);
		#1;
		{v1, l1, p1} = {res_valid, lines, lines_phase};
		@(posedge mclk);
		#1;
		vend = res_valid;
	endtask : srch
////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4000) @(posedge mclk);
		err_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		test_done();
	end

	initial begin
		{rstn, aclr_local, aclr_global, sclr, wr_en, read_strobe, enc_sel} = 7'h00;
		{in_ce, out_ce, mode, reg_opt, wr_addr, lut_addr} = {2'h3, CS_SINGLE, 16'h0000};
		{wr_data, wr_care, srch_data} = {32'h0000_0000, CS_CARE_ALL, 32'h0000_0000};
		err_count = 0;
		total_checks = 0;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		#1;
		chk_bit(match, 1'b0, "match after reset");
		chk_bit(srch_ready, 1'b1, "ready after reset");
		srch(32'h00FF_5AC3, 1);
		chk_bit(m0, 1'b0, "preloaded entry matched");
		chk_val(32'(l0), 32'h0, "lines on miss");
		@(posedge mclk);
		lut_addr <= 5'h07;
		@(posedge mclk);
		#1;
		chk_val(lut_data, 32'h07F8_5DC3, "lookup word");
		tend("preload");

		cfg(CS_SINGLE, 1'b1, 6'h00);
		wr(5'h0C, 32'hFA12_0C0C, CS_CARE_ALL);
		srch(32'hFA12_0C0C, 1);
		chk_bit(m0, 1'b1, "match flag");
		chk_val(32'(i0), 32'h0C, "encoded index");
		chk_bit(v1, 1'b0, "single result one cycle");
		wr(5'h03, 32'h1234_5600, 32'hFFFF_FF00);
		srch(32'h1234_56A5, 1);
		chk_val(32'({m0, i0}), 32'h23, "dont-care match");
		srch(32'h0BAD_0000, 1);
		chk_bit(m0, 1'b0, "miss flag");
		tend("encoded");

		cfg(CS_SINGLE, 1'b0, 6'h00);
		wr(5'h05, 32'h0000_7E57, CS_CARE_ALL);
		wr(5'h06, 32'h8000_7E57, CS_CARE_ALL);
		srch(32'h8000_7E57, 1);
		chk_val(32'({p0, l0}), 32'h1_0020, "odd bank first cycle");
		chk_val(32'({p1, l1}), 32'h0_0000, "odd bank second cycle");
		srch(32'h0000_7E57, 1);
		chk_val(32'(l0), 32'h0040, "even bank lines");
		tend("unencoded");

		cfg(CS_MULTI, 1'b0, 6'h00);
		wr(5'h09, 32'h0000_C0DE, CS_CARE_ALL);
		wr(5'h19, 32'h0000_C0DE, CS_CARE_ALL);
		srch(32'h8000_C0DE, 1);
		chk_val({l0, l1}, 32'h0200_0200, "multiple lines");
		chk_val(32'({v1, vend}), 32'h2, "two result cycles");
		chk_val(32'({enc_hit, enc_idx}), 32'h29, "lowest match");
		tend("multiple");

		cfg(CS_FAST, 1'b0, 6'h00);
		wr(5'h14, 32'h0000_F00D, CS_CARE_ALL);
		srch(32'h0000_F00D, 1);
		chk_bit(m0, 1'b0, "fast beyond sixteen");
		wr(5'h02, 32'h0000_F00D, CS_CARE_ALL);
		srch(32'h0000_F00D, 1);
		chk_val(32'({m0, v1, l0}), 32'h2_0004, "fast lines");
		tend("fast");

		cfg(CS_SINGLE, 1'b1, 6'h02);
		srch(32'hFA12_0C0C, 2);
		chk_val(32'({v0, i0}), 32'h2C, "output stage");
		cfg(CS_SINGLE, 1'b1, 6'h24);
		srch(32'hFA12_0C0C, 2);
		chk_val(32'({v0, i0}), 32'h2C, "input stage");
		chk_bit(v1, 1'b0, "input stage single take");
		cfg(CS_SINGLE, 1'b1, 6'h00);
		in_ce       <= 1'b0;
		read_strobe <= 1'b1;
		@(posedge mclk);
		@(posedge mclk);
		#1;
		chk_bit(res_valid, 1'b0, "strobe with input enable low");
		@(posedge mclk);
		read_strobe <= 1'b0;
		in_ce       <= 1'b1;
		sclr        <= 1'b1;
		@(posedge mclk);
		sclr <= 1'b0;
		#1;
		chk_bit(match, 1'b0, "synchronous clear");
		tend("controls");

		for (int k = 0; k < 2; k++) begin
			wr(5'h0C, 32'hFA12_0C0C, CS_CARE_ALL);
			srch(32'hFA12_0C0C, 1);
			chk_bit(m0, 1'b1, "match before clear");
			@(posedge mclk);
			aclr_local  <= (k == 0);
			aclr_global <= (k == 1);
			#1;
			chk_bit(match, 1'b0, "asynchronous clear");
			@(posedge mclk);
			{aclr_local, aclr_global} <= 2'h0;
		end
		tend("clears");
		test_done();
	end
endmodule : tb_top
